// file: core/tcc_pkg.sv
package tcc_pkg;

    localparam int          TCC_CHANNELS     = 6;
    // ------------------------------------------------------------
    // register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0]  TCC_OFS_CTRL     = 8'h00;
    localparam logic [7:0]  TCC_OFS_CNT_HI   = 8'h04;
    localparam logic [7:0]  TCC_OFS_CNT_LO   = 8'h08;
    localparam logic [7:0]  TCC_OFS_PER_HI   = 8'h0C;
    localparam logic [7:0]  TCC_OFS_PER_LO   = 8'h10;
    localparam logic [2:0]  TCC_REGION_CHCTL = 3'h1;
    localparam logic [2:0]  TCC_REGION_CHVAL = 3'h2;
    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int          TCC_SC_FLAG      = 7;
    localparam int          TCC_SC_IE        = 6;
    localparam int          TCC_SC_HALT      = 5;
    localparam int          TCC_SC_CLR       = 4;
    localparam int          TCC_CH_FLAG      = 7;
    localparam int          TCC_CH_IE        = 6;
    localparam int          TCC_CH_MSB       = 5;
    localparam int          TCC_CH_MSA       = 4;
    localparam int          TCC_CH_ELSB      = 3;
    localparam int          TCC_CH_ELSA      = 2;
    localparam logic [2:0]  TCC_PS_EXT       = 3'h7;
    localparam logic [5:0]  TCC_CH_BUFFERED  = 6'h15;
    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [15:0] TCC_PERIOD_RST   = 16'hFFFF;
    localparam logic [15:0] TCC_CNT_RST      = 16'h0000;

    typedef struct packed {
        logic [15:0]      cnt;
        logic [5:0]       pre;
        logic [15:0]      period;
        logic [2:0]       ps;
        logic             overflow_irq_enable;
        logic             halt;
        logic             ovf;
        logic             ovf_armed;
        logic [7:0]       lo_buf;
        logic             lo_held;
        logic             period_hold;
        logic [5:0][6:0]  ch_ctl;
        logic [5:0]       ch_flag;
        logic [5:0]       ch_armed;
        logic [5:0][15:0] ch_val;
        logic [5:0]       pin_s1;
        logic [5:0]       pin_s2;
        logic [5:0]       pin_prev;
        logic             dp_valid;
        logic             dp_write;
        logic [7:0]       dp_addr;
        logic [31:0]      hrdata;
        logic             hreadyout;
        logic             hresp;
        logic             ovf_irq;
        logic [5:0]       ch_irq;
        logic             ch0_oe;
    } tcc_state_t;

    localparam tcc_state_t TCC_STATE_RST = '{
        period:    TCC_PERIOD_RST,
        cnt:       TCC_CNT_RST,
        halt:      1'b1,
        hreadyout: 1'b1,
        default:   '0
    };

endpackage : tcc_pkg

// file: core/tcc_core.sv
// The address map and the AHB-Lite slave port were decided locally.
`timescale 1ns/1ps
module tcc_core (
    input  wire logic                           sys_clk,
    input  wire logic                           rst_n,
    input  wire logic                           hsel,
    input  wire logic [31:0]                    haddr,
    input  wire logic [1:0]                     htrans,
    input  wire logic                           hwrite,
    input  wire logic [2:0]                     hsize,
    input  wire logic [31:0]                    hwdata,
    input  wire logic                           hready,
    output logic                                hreadyout,
    output logic                                hresp,
    output logic [31:0]                         hrdata,
    input  wire logic [tcc_pkg::TCC_CHANNELS-1:0] chan_pin,
    input  wire logic                           pin_direction_bit,
    input  wire logic                           debug_break,
    output logic                                ch0_pin_oe,
    output logic                                overflow_irq,
    output logic [tcc_pkg::TCC_CHANNELS-1:0]    channel_irq
);
    import tcc_pkg::*;

    tcc_state_t s;
    tcc_state_t n;

    logic [5:0]  rise;
    logic [5:0]  fall;
    logic        run;
    logic        ext;
    logic [5:0]  mask;
    logic        tick;
    logic        clr;
    logic [15:0] cnt_inc;
    logic        ovf_ev;
    logic [5:0]  ch_ev;
    logic        take;
    logic        wr;
    logic [7:0]  wa;
    logic [2:0]  wi;
    logic [7:0]  ra;
    logic [2:0]  ri;
    logic        cap;
    logic        cmp;
    logic        msb;
    logic [31:0] rd;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        n = s;
        rise = '0;
        fall = '0;
        ch_ev = '0;
        cap = 1'b0;
        cmp = 1'b0;
        msb = 1'b0;
        rd = '0;

        // pin synchronisers; edges come from the second stage and its delayed copy pin_prev
        n.pin_s1 = chan_pin;
        n.pin_s2 = s.pin_s1;
        n.pin_prev = s.pin_s2;
        rise = s.pin_s2 & ~s.pin_prev;
        fall = ~s.pin_s2 & s.pin_prev;

        // bus data phase of a write
        wr = s.dp_valid & s.dp_write;
        wa = s.dp_addr;
        wi = wa[4:2];
        clr = wr & (wa == TCC_OFS_CTRL) & hwdata[TCC_SC_CLR];

        if (wr) begin
            if (wa == TCC_OFS_CTRL) begin
                n.overflow_irq_enable = hwdata[TCC_SC_IE];
                n.halt = hwdata[TCC_SC_HALT];
                n.ps = hwdata[2:0];
                if (s.ovf_armed && !hwdata[TCC_SC_FLAG]) begin
                    n.ovf = 1'b0;
                end
                n.ovf_armed = 1'b0;
                if (clr) begin
                    n.cnt = TCC_CNT_RST;
                    n.pre = '0;
                    n.lo_buf = '0;
                    n.lo_held = 1'b0;
                end
            end else if (wa == TCC_OFS_PER_HI) begin
                n.period[15:8] = hwdata[7:0];
                n.period_hold = 1'b1;
            end else if (wa == TCC_OFS_PER_LO) begin
                n.period[7:0] = hwdata[7:0];
                n.period_hold = 1'b0;
            end else if (wa[7:5] == TCC_REGION_CHCTL && wi < 3'd6) begin
                n.ch_ctl[wi] = hwdata[6:0];
                if (!TCC_CH_BUFFERED[wi]) begin
                    n.ch_ctl[wi][TCC_CH_MSB] = 1'b0;
                end
                if (s.ch_armed[wi] && !hwdata[TCC_CH_FLAG]) begin
                    n.ch_flag[wi] = 1'b0;
                end
                n.ch_armed[wi] = 1'b0;
            end else if (wa[7:5] == TCC_REGION_CHVAL && wi < 3'd6) begin
                n.ch_val[wi] = hwdata[15:0];
            end
        end

        // counter clock: prescaler or synchronised external edge
        run = ~n.halt & ~debug_break & ~clr;
        ext = (s.ps == TCC_PS_EXT);
        mask = 6'((7'd1 << s.ps) - 7'd1);
        if (run && !ext) begin
            n.pre = s.pre + 6'd1;
        end
        tick = run & (ext ? rise[0] : &(s.pre | ~mask));

        cnt_inc = (s.cnt == s.period) ? TCC_CNT_RST : s.cnt + 16'd1;
        if (tick) begin
            n.cnt = cnt_inc;
        end
        ovf_ev = tick & (cnt_inc == s.period) & ~n.period_hold;

        // hardware set beats a same-cycle clear and disarms it
        if (ovf_ev) begin
            n.ovf = 1'b1;
            n.ovf_armed = 1'b0;
        end

        // channel capture and compare
        for (int i = 0; i < TCC_CHANNELS; i++) begin
            msb = s.ch_ctl[i][TCC_CH_MSB];
            cap = ~msb & ~s.ch_ctl[i][TCC_CH_MSA]
                & (s.ch_ctl[i][TCC_CH_ELSB] | s.ch_ctl[i][TCC_CH_ELSA]);
            cmp = msb | s.ch_ctl[i][TCC_CH_MSA];
            if (cap && !s.halt && !debug_break) begin
                ch_ev[i] = (s.ch_ctl[i][TCC_CH_ELSA] & rise[i])
                         | (s.ch_ctl[i][TCC_CH_ELSB] & fall[i]);
            end else if (cmp && tick) begin
                ch_ev[i] = (cnt_inc == s.ch_val[i]);
            end
            if (ch_ev[i]) begin
                n.ch_flag[i] = 1'b1;
                n.ch_armed[i] = 1'b0;
                if (cap) begin
                    n.ch_val[i] = s.cnt;
                end
            end
        end

        // bus address phase; read data comes from the updated state
        take = hsel & htrans[1] & hready;
        n.dp_valid = take;
        n.dp_write = hwrite;
        n.dp_addr = haddr[7:0];
        ra = haddr[7:0];
        ri = ra[4:2];

        if (ra == TCC_OFS_CTRL) begin
            rd[7:0] = {n.ovf, n.overflow_irq_enable, n.halt, 2'b00, n.ps};
        end else if (ra == TCC_OFS_CNT_HI) begin
            rd[7:0] = n.cnt[15:8];
        end else if (ra == TCC_OFS_CNT_LO) begin
            rd[7:0] = n.lo_held ? n.lo_buf : n.cnt[7:0];
        end else if (ra == TCC_OFS_PER_HI) begin
            rd[7:0] = n.period[15:8];
        end else if (ra == TCC_OFS_PER_LO) begin
            rd[7:0] = n.period[7:0];
        end else if (ra[7:5] == TCC_REGION_CHCTL && ri < 3'd6) begin
            rd[7:0] = {n.ch_flag[ri], n.ch_ctl[ri]};
        end else if (ra[7:5] == TCC_REGION_CHVAL && ri < 3'd6) begin
            rd[15:0] = n.ch_val[ri];
        end

        if (take && !hwrite) begin
            n.hrdata = rd;
            if (ra == TCC_OFS_CTRL && n.ovf) begin
                n.ovf_armed = 1'b1;
            end else if (ra == TCC_OFS_CNT_HI && !n.lo_held) begin
                n.lo_buf = n.cnt[7:0];
                n.lo_held = 1'b1;
            end else if (ra == TCC_OFS_CNT_LO) begin
                n.lo_held = 1'b0;
            end else if (ra[7:5] == TCC_REGION_CHCTL && ri < 3'd6) begin
                if (n.ch_flag[ri]) begin
                    n.ch_armed[ri] = 1'b1;
                end
            end
        end else begin
            n.hrdata = '0;
        end

        // zero wait states, always okay
        n.hreadyout = 1'b1;
        n.hresp = 1'b0;

        // outputs, registered
        n.ovf_irq = n.ovf & n.overflow_irq_enable & ~n.period_hold;
        n.ch_irq = n.ch_flag & {n.ch_ctl[5][TCC_CH_IE], n.ch_ctl[4][TCC_CH_IE],
                                n.ch_ctl[3][TCC_CH_IE], n.ch_ctl[2][TCC_CH_IE],
                                n.ch_ctl[1][TCC_CH_IE], n.ch_ctl[0][TCC_CH_IE]};
        n.ch0_oe = pin_direction_bit & (n.ps != TCC_PS_EXT);
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            s <= TCC_STATE_RST;
        end else begin
            s <= n;
        end
    end

    assign hreadyout = s.hreadyout;
    assign hresp = s.hresp;
    assign hrdata = s.hrdata;
    assign ch0_pin_oe = s.ch0_oe;
    assign overflow_irq = s.ovf_irq;
    assign channel_irq = s.ch_irq;

endmodule : tcc_core

// file: test/tcc_props.sv
`timescale 1ns/1ps
module tcc_props (
    input wire logic        sys_clk,
    input wire logic        rst_n,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic [31:0] hrdata,
    input wire logic        pin_direction_bit,
    input wire logic        ch0_pin_oe,
    input wire logic        overflow_irq,
    input wire logic [5:0]  channel_irq
);
    logic       rd_q;
    logic [7:0] a_q;
    // ------------------------------------------------------------
    // data phase tracking
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        rd_q <= rst_n && hsel && htrans[1] && hready && !hwrite;
        a_q  <= haddr[7:0];
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    a_ready_high: assert property (hreadyout) else $error("hreadyout low");
    a_resp_okay: assert property (!hresp) else $error("hresp not okay");
    a_idle_zero: assert property (!rd_q |-> hrdata == 32'h0) else $error("hrdata not zero");
    a_clear_reads: assert property (rd_q && a_q == 8'h00 |-> !hrdata[4])
        else $error("clear bit read as one");
    a_count_byte: assert property (rd_q && a_q inside {8'h04, 8'h08} |-> hrdata[31:8] == 24'h0)
        else $error("count read wider than a byte");
    a_chan_nobuf: assert property (rd_q && a_q inside {8'h24, 8'h2C, 8'h34} |-> !hrdata[5])
        else $error("buffered bit on odd channel");
    a_pin_input: assert property (!pin_direction_bit |=> !ch0_pin_oe)
        else $error("pin driven while input");
    a_irq_reset: assert property ($rose(rst_n) |-> !overflow_irq && channel_irq == 6'h0)
        else $error("irq set after reset");
endmodule : tcc_props

bind tcc_core tcc_props i_tcc_props (.sys_clk, .rst_n, .hsel, .haddr, .htrans, .hwrite,
    .hready, .hreadyout, .hresp, .hrdata, .pin_direction_bit, .ch0_pin_oe, .overflow_irq,
    .channel_irq);

// file: test/tcc_ext_clk.sv
`timescale 1ns/1ps
module tcc_ext_clk (
    output logic ext_clk
);
    initial ext_clk = 1'b0;
    // 2.5 MHz pulses, stands low between bursts
    task automatic pulse(input int n);
        repeat (n) begin
            #200 ext_clk = 1'b1;
            #200 ext_clk = 1'b0;
        end
    endtask : pulse
endmodule : tcc_ext_clk

// file: test/tcc_core_tb.sv
`timescale 1ns/1ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin fails++; \
    $display("[FAIL] %0t got %h exp %h", $time, (a), (e)); end end
module tcc_core_tb;
    import tcc_pkg::*;
    logic        sys_clk, rst_n, hsel, hwrite, hready, hresp, pin_dir, dbg, ext_clk, oe, ovf;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] haddr, hwdata, hrdata, v;
    logic [15:0] c;
    logic [5:0]  chirq;
    int          fails, n_checks, k;
    tcc_core i_tcc_core (.sys_clk(sys_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .chan_pin({5'h0, ext_clk}),
        .pin_direction_bit(pin_dir), .debug_break(dbg), .ch0_pin_oe(oe),
        .overflow_irq(ovf), .channel_irq(chirq));
    tcc_ext_clk i_tcc_ext_clk (.ext_clk(ext_clk));
    // ------------------------------------------------------------
    // bus tasks
    // ------------------------------------------------------------
    task automatic print_verdict;
        $display("checks %0d fails %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : print_verdict
    task automatic wait_rdy;
        int i;
        for (i = 0; i < 50; i++) begin
            @(posedge sys_clk);
            if (hready === 1'b1) break;
        end
        if (i == 50) begin
            fails++;
            print_verdict;
        end
    endtask : wait_rdy
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        haddr  <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'b10;
        hsel   <= 1'b1;
        wait_rdy;
        htrans <= 2'b00;
        hsel   <= 1'b0;
        hwdata <= d;
        wait_rdy;
        q = hrdata;
    endtask : xfer
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        xfer(1'b1, a, d, q);
    endtask : wr
    task automatic chk_rd(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        xfer(1'b0, a, 32'h0, q);
        `CHK(q, e)
    endtask : chk_rd
    // sync path needs a few clocks after the last edge
    task automatic ext(input int n);
        i_tcc_ext_clk.pulse(n);
        repeat (10) @(posedge sys_clk);
    endtask : ext
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        {rst_n, hsel, hwrite, htrans, haddr, hwdata, pin_dir, dbg} = '0;
        hsize = 3'h2;
        repeat (20) @(posedge sys_clk);
        rst_n   <= 1'b1;
        pin_dir <= 1'b1;
        @(posedge sys_clk);
        chk_rd(8'h00, 32'h20);
        chk_rd(8'h0C, 32'hFF);
        chk_rd(8'h10, 32'hFF);
        repeat (20) @(posedge sys_clk);
        chk_rd(8'h08, 32'h0);
        chk_rd(8'h14, 32'h0);
        chk_rd(8'h24, 32'h0);
        for (k = 0; k < 7; k++) begin
            wr(8'h00, 32'h30 | k);
            chk_rd(8'h08, 32'h0);
            wr(8'h00, k);
            repeat (256) @(posedge sys_clk);
            wr(8'h00, 32'h20 | k);
            @(posedge sys_clk);
            `CHK(oe, 1'b1)
            chk_rd(8'h00, 32'h20 | k);
            xfer(1'b0, 8'h04, 32'h0, v);
            c[15:8] = v[7:0];
            xfer(1'b0, 8'h08, 32'h0, v);
            c[7:0] = v[7:0];
            `CHK(c >= (256 >> k) && c <= (260 >> k) + 1, 1'b1)
        end
        wr(8'h00, 32'h37);
        wr(8'h00, 32'h07);
        @(posedge sys_clk);
        `CHK(oe, 1'b0)
        ext(300);
        chk_rd(8'h04, 32'h01);
        ext(5);
        chk_rd(8'h04, 32'h01);
        chk_rd(8'h08, 32'h2C);
        chk_rd(8'h08, 32'h31);
        wr(8'h00, 32'h37);
        wr(8'h0C, 32'h0);
        wr(8'h10, 32'h3);
        wr(8'h00, 32'h47);
        ext(3);
        chk_rd(8'h00, 32'hC7);
        `CHK(ovf, 1'b1)
        ext(1);
        chk_rd(8'h08, 32'h0);
        wr(8'h00, 32'hC7);
        chk_rd(8'h00, 32'hC7);
        ext(4);
        wr(8'h00, 32'h47);
        chk_rd(8'h00, 32'hC7);
        wr(8'h00, 32'h47);
        chk_rd(8'h00, 32'h47);
        `CHK(ovf, 1'b0)
        wr(8'h0C, 32'h0);
        ext(4);
        chk_rd(8'h00, 32'h47);
        wr(8'h10, 32'h3);
        ext(4);
        chk_rd(8'h00, 32'hC7);
        wr(8'h00, 32'h37);
        wr(8'h40, 32'h2);
        wr(8'h20, 32'h50);
        wr(8'h00, 32'h07);
        ext(2);
        chk_rd(8'h20, 32'hD0);
        `CHK(chirq, 6'h01)
        wr(8'h20, 32'hD0);
        chk_rd(8'h20, 32'hD0);
        wr(8'h20, 32'h50);
        chk_rd(8'h20, 32'h50);
        dbg <= 1'b1;
        ext(3);
        chk_rd(8'h08, 32'h2);
        dbg <= 1'b0;
        wr(8'h00, 32'h27);
        wr(8'h20, 32'h04);
        ext(2);
        chk_rd(8'h20, 32'h04);
        wr(8'h00, 32'h07);
        ext(1);
        chk_rd(8'h20, 32'h84);
        wr(8'h24, 32'h20);
        chk_rd(8'h24, 32'h0);
        wr(8'h00, 32'h20);
        @(posedge sys_clk);
        `CHK(oe, 1'b1)
        pin_dir <= 1'b0;
        repeat (2) @(posedge sys_clk);
        `CHK(oe, 1'b0)
        print_verdict;
    end
endmodule : tcc_core_tb
